// ### rtl/set_features_pkg.sv
/*
 Package for the feature-setting command decoder: register offsets, subcommand
 codes, field layouts, reset values and carrier types.
 Assumes a 32-bit APB bus with one aligned word per register.
*/
package set_features_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SETTINGS = 8'h08;
    localparam logic [7:0] OFS_MODES = 8'h0c;
    localparam logic [7:0] OFS_POWER = 8'h10;
    localparam logic [7:0] OFS_FLUSH = 8'h14;

    // Subcommand codes
    localparam logic [7:0] SC_PIO8_ON = 8'h01;
    localparam logic [7:0] SC_WCACHE_ON = 8'h02;
    localparam logic [7:0] SC_XFER_MODE = 8'h03;
    localparam logic [7:0] SC_APM_ON = 8'h05;
    localparam logic [7:0] SC_PUIS_ON = 8'h06;
    localparam logic [7:0] SC_SPINUP = 8'h07;
    localparam logic [7:0] SC_CPM1_ON = 8'h0a;
    localparam logic [7:0] SC_MSN_OFF = 8'h31;
    localparam logic [7:0] SC_ACOUS_ON = 8'h42;
    localparam logic [7:0] SC_LOOKAHEAD_OFF = 8'h55;
    localparam logic [7:0] SC_RELINT_ON = 8'h5d;
    localparam logic [7:0] SC_SVCINT_ON = 8'h5e;
    localparam logic [7:0] SC_REVERT_OFF = 8'h66;
    localparam logic [7:0] SC_PIO8_OFF = 8'h81;
    localparam logic [7:0] SC_WCACHE_OFF = 8'h82;
    localparam logic [7:0] SC_APM_OFF = 8'h85;
    localparam logic [7:0] SC_PUIS_OFF = 8'h86;
    localparam logic [7:0] SC_CPM1_OFF = 8'h8a;
    localparam logic [7:0] SC_MSN_ON = 8'h95;
    localparam logic [7:0] SC_LOOKAHEAD_ON = 8'haa;
    localparam logic [7:0] SC_ACOUS_OFF = 8'hc2;
    localparam logic [7:0] SC_REVERT_ON = 8'hcc;
    localparam logic [7:0] SC_RELINT_OFF = 8'hdd;
    localparam logic [7:0] SC_SVCINT_OFF = 8'hde;

    // Transfer type field, sector count bits 7:3
    localparam logic [4:0] XT_PIO_DEFAULT = 5'h00;
    localparam logic [4:0] XT_PIO_FLOW = 5'h01;
    localparam logic [4:0] XT_MWDMA = 5'h04;
    localparam logic [4:0] XT_UDMA = 5'h08;
    localparam logic [2:0] XM_DEFAULT = 3'h0;
    localparam logic [2:0] XM_NO_IORDY = 3'h1;
    localparam logic [2:0] PIO_IORDY_MIN = 3'h3;

    // Power levels
    localparam logic [7:0] APM_RSVD_LO = 8'h00;
    localparam logic [7:0] APM_RSVD_HI = 8'hff;
    localparam logic [7:0] APM_NO_SPINDOWN = 8'h80;

    // Status and error bit positions
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DF = 5;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_ABRT = 2;

    // Command register field positions
    localparam int CMD_FEAT_LSB = 0;
    localparam int CMD_COUNT_LSB = 8;
    localparam int CMD_GO_BIT = 16;

    typedef struct packed {
        logic pio8;
        logic wcache;
        logic apm_en;
        logic puis;
        logic cpm1;
        logic msn;
        logic acous_en;
        logic lookahead;
        logic relint;
        logic svcint;
        logic revert;
        logic iordy_off;
    } settings_type;

    typedef struct packed {
        logic pio_valid;
        logic [2:0] pio_mode;
        logic mw_valid;
        logic [2:0] mw_mode;
        logic udma_valid;
        logic [2:0] udma_mode;
    } modes_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_FLUSH = 2'b11,
        ST_DONE = 2'b10
    } state_type;

    localparam settings_type SETTINGS_RESET = '{default: 1'b0, wcache: 1'b1, lookahead: 1'b1, revert: 1'b1};
    localparam logic [7:0] APM_RESET = 8'hfe;
    localparam logic [7:0] ACOUS_RESET = 8'hfe;
    // DRDY and DSC set, all else clear
    localparam logic [7:0] STATUS_RESET = 8'h50;

endpackage : set_features_pkg

// ### rtl/set_features_decoder.sv
/*
 Feature-setting command decoder with APB register access.
 Software places subcommand and sector count in the command register and sets
 the go bit; the block updates stored settings and posts status and error.
 Assumes a single clock, an external cache that answers a flush request with
 flush_done, and a host that only issues commands while DRDY reads one.
*/
// Added by the designer: the placing of the registers and register access over APB.
// Overview of operation
// - Error completion: BSY DRQ clear, DRDY set, ERR
// - Reset defaults are implementation chosen parameters
// - 01h/81h toggle 8-bit PIO, compact-card only
// - 8-bit PIO narrows data port to low byte
// - 02h/82h write cache; disable flushes first
// - 03h: type in bits 7:3, mode 2:0
// - Decode PIO, flow PIO, MWDMA, UDMA types
// - Zero selects default PIO; one disables IORDY
// - Accept every PIO mode up to highest
// - PIO mode three and up keeps IORDY
// - Accept every DMA mode up to highest
// - UDMA and MWDMA selection exclude each other
// - 05h stores power level 01h to FEh
// - Power levels 00h and FFh are rejected
// - Level 80h and above forbids spin-down
// - 85h disables power management, optional
// - AAh/55h read look-ahead on and off
// - 5Dh/DDh release, 5Eh/DEh service interrupt
// - CCh/66h revert to defaults on and off
// - Standby power-up, spin-up, card power, notification, acoustic
// - Unsupported code or value aborts with ABRT
`timescale 1ns/1ns
`default_nettype none

module set_features_decoder #(
    parameter bit HAS_PIO8 = 1'b0,
    parameter bit HAS_WCACHE = 1'b1,
    parameter bit HAS_IORDY_OFF = 1'b1,
    parameter bit HAS_APM_OFF = 1'b1,
    parameter bit HAS_ACOUS_OFF = 1'b1,
    parameter logic [2:0] PIO_MAX = 3'h4,
    parameter logic [2:0] MW_MAX = 3'h2,
    parameter logic [2:0] UDMA_MAX = 3'h5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic device_fault,
    input wire logic flush_done,
    output logic flush_req,
    output logic data_8bit,
    output logic iordy_en,
    output logic spindown_allowed,
    output set_features_pkg::settings_type settings,
    output set_features_pkg::modes_type modes,
    output logic [7:0] apm_level,
    output logic [7:0] acous_level,
    output logic spinup_pulse
);

    set_features_pkg::state_type state_r;
    set_features_pkg::settings_type settings_r;
    set_features_pkg::settings_type settings_nxt;
    set_features_pkg::modes_type modes_r;
    set_features_pkg::modes_type modes_nxt;
    logic [7:0] apm_r;
    logic [7:0] apm_nxt;
    logic [7:0] acous_r;
    logic [7:0] acous_nxt;
    logic [7:0] feat_r;
    logic [7:0] count_r;
    logic [7:0] status_r;
    logic [7:0] error_r;
    logic [31:0] prdata_r;
    logic abort;
    logic need_flush;
    logic spinup_r;
    logic spinup_nxt;
    logic wr_en;
    logic rd_en;
    logic go;
    logic mapped;

    // True when the mode number is within the supported ceiling
    function automatic logic mode_ok(input logic [2:0] mode, input logic [2:0] max);
        mode_ok = (mode <= max);
    endfunction : mode_ok

    function automatic logic addr_hit(input logic [7:0] addr);
        addr_hit = (addr == set_features_pkg::OFS_COMMAND) || (addr == set_features_pkg::OFS_STATUS)
            || (addr == set_features_pkg::OFS_SETTINGS) || (addr == set_features_pkg::OFS_MODES)
            || (addr == set_features_pkg::OFS_POWER) || (addr == set_features_pkg::OFS_FLUSH);
    endfunction : addr_hit

    // Zero-wait APB slave; writes land in the access phase
    assign pready = 1'b1;
    assign mapped = addr_hit(paddr);
    assign pslverr = psel && penable && !mapped;
    assign wr_en = clk_en && psel && penable && pwrite && mapped;
    assign rd_en = clk_en && psel && penable && !pwrite;
    // Command accepted only while idle and ready
    assign go = wr_en && (paddr == set_features_pkg::OFS_COMMAND)
        && pwdata[set_features_pkg::CMD_GO_BIT] && (state_r == set_features_pkg::ST_IDLE)
        && status_r[set_features_pkg::ST_DRDY];

    always_comb
    begin
        settings_nxt = settings_r;
        modes_nxt = modes_r;
        apm_nxt = apm_r;
        acous_nxt = acous_r;
        abort = 1'b0;
        need_flush = 1'b0;
        spinup_nxt = 1'b0;
        case (feat_r)
            set_features_pkg::SC_PIO8_ON, set_features_pkg::SC_PIO8_OFF:
            begin
                if (HAS_PIO8)
                    settings_nxt.pio8 = (feat_r == set_features_pkg::SC_PIO8_ON);
                else
                    abort = 1'b1;
            end
            set_features_pkg::SC_WCACHE_ON, set_features_pkg::SC_WCACHE_OFF:
            begin
                if (!HAS_WCACHE)
                    abort = 1'b1;
                else if (feat_r == set_features_pkg::SC_WCACHE_ON)
                    settings_nxt.wcache = 1'b1;
                else
                begin
                    settings_nxt.wcache = 1'b0;
                    need_flush = 1'b1;
                end
            end
            set_features_pkg::SC_XFER_MODE:
            begin
                case (count_r[7:3])
                    set_features_pkg::XT_PIO_DEFAULT:
                    begin
                        if (count_r[2:0] == set_features_pkg::XM_DEFAULT)
                        begin
                            modes_nxt.pio_valid = 1'b0;
                            settings_nxt.iordy_off = 1'b0;
                        end
                        else if (count_r[2:0] == set_features_pkg::XM_NO_IORDY && HAS_IORDY_OFF)
                        begin
                            modes_nxt.pio_valid = 1'b0;
                            settings_nxt.iordy_off = 1'b1;
                        end
                        else
                            abort = 1'b1;
                    end
                    set_features_pkg::XT_PIO_FLOW:
                    begin
                        if (mode_ok(count_r[2:0], PIO_MAX))
                        begin
                            modes_nxt.pio_valid = 1'b1;
                            modes_nxt.pio_mode = count_r[2:0];
                            settings_nxt.iordy_off = 1'b0;
                        end
                        else
                            abort = 1'b1;
                    end
                    set_features_pkg::XT_MWDMA:
                    begin
                        if (mode_ok(count_r[2:0], MW_MAX))
                        begin
                            modes_nxt.mw_valid = 1'b1;
                            modes_nxt.mw_mode = count_r[2:0];
                            modes_nxt.udma_valid = 1'b0;
                        end
                        else
                            abort = 1'b1;
                    end
                    set_features_pkg::XT_UDMA:
                    begin
                        // Cable check above mode 2 is the host's duty
                        if (mode_ok(count_r[2:0], UDMA_MAX))
                        begin
                            modes_nxt.udma_valid = 1'b1;
                            modes_nxt.udma_mode = count_r[2:0];
                            modes_nxt.mw_valid = 1'b0;
                        end
                        else
                            abort = 1'b1;
                    end
                    default:
                        abort = 1'b1;
                endcase
            end
            set_features_pkg::SC_APM_ON:
            begin
                if (count_r == set_features_pkg::APM_RSVD_LO || count_r == set_features_pkg::APM_RSVD_HI)
                    abort = 1'b1;
                else
                begin
                    settings_nxt.apm_en = 1'b1;
                    apm_nxt = count_r;
                end
            end
            set_features_pkg::SC_APM_OFF:
            begin
                if (HAS_APM_OFF)
                    settings_nxt.apm_en = 1'b0;
                else
                    abort = 1'b1;
            end
            set_features_pkg::SC_PUIS_ON, set_features_pkg::SC_PUIS_OFF:
                settings_nxt.puis = (feat_r == set_features_pkg::SC_PUIS_ON);
            set_features_pkg::SC_SPINUP:
                spinup_nxt = 1'b1;
            set_features_pkg::SC_CPM1_ON, set_features_pkg::SC_CPM1_OFF:
                settings_nxt.cpm1 = (feat_r == set_features_pkg::SC_CPM1_ON);
            set_features_pkg::SC_MSN_ON, set_features_pkg::SC_MSN_OFF:
                settings_nxt.msn = (feat_r == set_features_pkg::SC_MSN_ON);
            set_features_pkg::SC_ACOUS_ON:
            begin
                if (count_r == set_features_pkg::APM_RSVD_HI)
                    abort = 1'b1; // Aborted level keeps previous state
                else
                begin
                    settings_nxt.acous_en = 1'b1;
                    acous_nxt = count_r;
                end
            end
            set_features_pkg::SC_ACOUS_OFF:
            begin
                if (HAS_ACOUS_OFF)
                    settings_nxt.acous_en = 1'b0;
                else
                    abort = 1'b1;
            end
            set_features_pkg::SC_LOOKAHEAD_ON, set_features_pkg::SC_LOOKAHEAD_OFF:
                settings_nxt.lookahead = (feat_r == set_features_pkg::SC_LOOKAHEAD_ON);
            set_features_pkg::SC_RELINT_ON, set_features_pkg::SC_RELINT_OFF:
                settings_nxt.relint = (feat_r == set_features_pkg::SC_RELINT_ON);
            set_features_pkg::SC_SVCINT_ON, set_features_pkg::SC_SVCINT_OFF:
                settings_nxt.svcint = (feat_r == set_features_pkg::SC_SVCINT_ON);
            set_features_pkg::SC_REVERT_ON, set_features_pkg::SC_REVERT_OFF:
                settings_nxt.revert = (feat_r == set_features_pkg::SC_REVERT_ON);
            default:
                abort = 1'b1;
        endcase
    end

    // Command sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= set_features_pkg::ST_IDLE;
        else if (clk_en)
        begin
            case (state_r)
                set_features_pkg::ST_IDLE:
                    if (go)
                        state_r <= set_features_pkg::ST_EXEC;
                set_features_pkg::ST_EXEC:
                    state_r <= (need_flush && !abort) ? set_features_pkg::ST_FLUSH : set_features_pkg::ST_DONE;
                set_features_pkg::ST_FLUSH:
                    if (flush_done)
                        state_r <= set_features_pkg::ST_DONE;
                set_features_pkg::ST_DONE:
                    state_r <= set_features_pkg::ST_IDLE;
                default:
                    state_r <= set_features_pkg::ST_IDLE;
            endcase
        end
    end

    // Latched command inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            feat_r <= 8'h00;
            count_r <= 8'h00;
        end
        else if (clk_en && go)
        begin
            feat_r <= pwdata[set_features_pkg::CMD_FEAT_LSB +: 8];
            count_r <= pwdata[set_features_pkg::CMD_COUNT_LSB +: 8];
        end
    end

    // Stored settings; defaults are build parameters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            settings_r <= set_features_pkg::SETTINGS_RESET;
            modes_r <= '0;
            apm_r <= set_features_pkg::APM_RESET;
            acous_r <= set_features_pkg::ACOUS_RESET;
        end
        else if (clk_en && state_r == set_features_pkg::ST_EXEC && !abort)
        begin
            settings_r <= settings_nxt;
            modes_r <= modes_nxt;
            apm_r <= apm_nxt;
            acous_r <= acous_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            spinup_r <= 1'b0;
        else if (clk_en)
            spinup_r <= (state_r == set_features_pkg::ST_EXEC) && spinup_nxt && !abort;
    end

    // Status and error; BSY from acceptance to completion
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_r <= set_features_pkg::STATUS_RESET;
            error_r <= 8'h0;
        end
        else if (clk_en)
        begin
            if (go)
            begin
                status_r[set_features_pkg::ST_BSY] <= 1'b1;
                status_r[set_features_pkg::ST_DRDY] <= 1'b0;
            end
            else if (state_r == set_features_pkg::ST_EXEC)
            begin
                error_r <= '0;
                error_r[set_features_pkg::ER_ABRT] <= abort;
            end
            else if (state_r == set_features_pkg::ST_DONE)
            begin
                status_r[set_features_pkg::ST_BSY] <= 1'b0;
                status_r[set_features_pkg::ST_DRDY] <= 1'b1;
                status_r[set_features_pkg::ST_DSC] <= 1'b1;
                status_r[set_features_pkg::ST_DRQ] <= 1'b0;
                status_r[set_features_pkg::ST_DF] <= device_fault;
                status_r[set_features_pkg::ST_ERR] <= |error_r;
            end
        end
    end

    // Read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0;
        else if (clk_en && psel && !penable && !pwrite)
        begin
            case (paddr)
                set_features_pkg::OFS_COMMAND:
                    prdata_r <= {16'h0, count_r, feat_r};
                set_features_pkg::OFS_STATUS:
                    prdata_r <= {16'h0, error_r, status_r};
                set_features_pkg::OFS_SETTINGS:
                    prdata_r <= {20'h0, settings_r};
                set_features_pkg::OFS_MODES:
                    prdata_r <= {20'h0, modes_r};
                set_features_pkg::OFS_POWER:
                    prdata_r <= {16'h0, acous_r, apm_r};
                set_features_pkg::OFS_FLUSH:
                    prdata_r <= {31'h0, flush_req};
                default:
                    prdata_r <= 32'h0;
            endcase
        end
    end

    assign prdata = rd_en ? prdata_r : 32'h0;
    assign flush_req = (state_r == set_features_pkg::ST_FLUSH);
    assign data_8bit = settings_r.pio8;
    // IORDY held on at PIO mode three and above
    assign iordy_en = !settings_r.iordy_off
        || (modes_r.pio_valid && modes_r.pio_mode >= set_features_pkg::PIO_IORDY_MIN);
    assign spindown_allowed = settings_r.apm_en && (apm_r < set_features_pkg::APM_NO_SPINDOWN);
    assign settings = settings_r;
    assign modes = modes_r;
    assign apm_level = apm_r;
    assign acous_level = acous_r;
    assign spinup_pulse = spinup_r;

endmodule : set_features_decoder

`default_nettype wire

// ### test/flush_cache_model.sv
/*
 Cache partner: answers a flush request with flush_done after a chosen delay.
 Assumes the decoder holds flush_req until it has seen flush_done.
*/
`timescale 1ns/1ns
`default_nettype none
module flush_cache_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flush_req,
    input wire logic [3:0] delay,
    output logic flush_done
);
    logic [3:0] wait_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_r <= 4'h0;
            flush_done <= 1'b0;
        end
        else if (!flush_req)
        begin
            // Done drops one cycle after the request, never left standing
            wait_r <= 4'h0;
            flush_done <= 1'b0;
        end
        else if (wait_r >= delay)
            flush_done <= 1'b1;
        else
            wait_r <= wait_r + 4'h1;
    end
endmodule : flush_cache_model
`default_nettype wire

// ### test/set_features_decoder_chk.sv
/*
 Port checker for the feature-setting decoder.
 Bound into every decoder instance; sees top-level ports only.
*/
`timescale 1ns/1ns
`default_nettype none
module set_features_decoder_chk #(
    parameter bit HAS_PIO8 = 1'b0,
    parameter logic [2:0] PIO_MAX = 3'h4,
    parameter logic [2:0] MW_MAX = 3'h2,
    parameter logic [2:0] UDMA_MAX = 3'h5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic flush_req,
    input wire logic flush_done,
    input wire logic data_8bit,
    input wire logic iordy_en,
    input wire logic spindown_allowed,
    input wire set_features_pkg::settings_type settings,
    input wire set_features_pkg::modes_type modes,
    input wire logic [7:0] apm_level,
    input wire logic pslverr
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_dma_exclusive: assert property (!(modes.mw_valid && modes.udma_valid))
        else $error("both DMA kinds valid");
    a_no_spindown: assert property ((settings.apm_en && apm_level >= 8'h80) [*2] |-> !spindown_allowed)
        else $error("spin-down allowed at high level");
    a_iordy_kept: assert property ((modes.pio_valid && modes.pio_mode >= 3'h3) [*2] |-> iordy_en)
        else $error("IORDY off in fast PIO");
    a_level_legal: assert property (apm_level != 8'h00 && apm_level != 8'hff)
        else $error("reserved power level stored");
    a_pio8_absent: assert property (settings.pio8 |-> HAS_PIO8)
        else $error("8-bit PIO enabled without support");
    a_port_width: assert property (!settings.pio8 [*2] |-> !data_8bit)
        else $error("narrow port without 8-bit PIO");
    a_mode_caps: assert property ((!modes.udma_valid || modes.udma_mode <= UDMA_MAX) &&
        (!modes.mw_valid || modes.mw_mode <= MW_MAX) && (!modes.pio_valid || modes.pio_mode <= PIO_MAX))
        else $error("mode above maximum");
    a_flush_holds: assert property (flush_req && !flush_done && clk_en |=> flush_req)
        else $error("flush dropped before done");
    a_flush_ends: assert property (flush_req && flush_done && clk_en |-> ##[1:3] !flush_req)
        else $error("flush not ended after done");
    c_flush: cover property ($rose(flush_req));
    c_udma: cover property (modes.udma_valid);
    c_slverr: cover property (pslverr);
endmodule : set_features_decoder_chk
bind set_features_decoder set_features_decoder_chk #(.HAS_PIO8(HAS_PIO8), .PIO_MAX(PIO_MAX), .MW_MAX(MW_MAX),
    .UDMA_MAX(UDMA_MAX)) chk_inst (.*);
`default_nettype wire

// ### test/test_set_features_decoder.sv
/*
 Self-checking bench for the feature-setting decoder over APB.
 Assumes zero-wait APB, status polled for BSY clear, cache partner model.
*/
`timescale 1ns/1ns
`default_nettype none
module test_set_features_decoder;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, device_fault, flush_done, flush_req;
    logic data_8bit, iordy_en, spindown_allowed, spinup_pulse, slv;
    logic [7:0] paddr, apm_level, acous_level;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] delay;
    set_features_pkg::settings_type settings;
    set_features_pkg::modes_type modes;
    int n_mismatch, check_count, spins;
    logic [7:0] on_c [7] = '{8'haa, 8'h5d, 8'h5e, 8'hcc, 8'h06, 8'h0a, 8'h95};
    logic [7:0] off_c [7] = '{8'h55, 8'hdd, 8'hde, 8'h66, 8'h86, 8'h8a, 8'h31};
    int bit_c [7] = '{4, 3, 2, 1, 8, 7, 6};
    logic [7:0] lv [4] = '{8'h01, 8'h80, 8'hfd, 8'hfe};
    set_features_decoder set_features_decoder_inst (.*);
    flush_cache_model flush_cache_model_inst (.*);
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // A pulse longer than one cycle counts once per cycle
    always @(posedge pclk) if (spinup_pulse === 1'b1) spins++;
    task check(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task issue(input logic [7:0] f, input logic [7:0] c);
        apb(1'b1, 8'h00, {15'h0, 1'b1, c, f});
    endtask : issue
    task finish(input logic ab);
        int n;
        n = 0;
        rd(8'h04);
        while (q[7] !== 1'b0 && n < 30)
        begin
            rd(8'h04);
            n++;
        end
        check(32'({q[10], q[7], q[6], q[5], q[3], q[0]}), 32'({ab, 2'b01, device_fault, 1'b0, ab}));
    endtask : finish
    task cmd(input logic [7:0] f, input logic [7:0] c, input logic ab);
        issue(f, c);
        finish(ab);
    endtask : cmd
    task t_reset;
        rd(8'h04);
        check(32'(q[15:0]), 32'h50);
        rd(8'h08);
        check(32'(q[11:0]), 32'(set_features_pkg::SETTINGS_RESET));
        rd(8'h10);
        check(32'(q[15:0]), 32'({set_features_pkg::ACOUS_RESET, set_features_pkg::APM_RESET}));
        rd(8'h20);
        check(32'(slv), 32'h1);
    endtask : t_reset
    task t_toggles;
        for (int i = 0; i < 7; i++)
        begin
            cmd(on_c[i], 8'h00, 1'b0);
            check(32'(settings[bit_c[i]]), 32'h1);
            cmd(off_c[i], 8'h00, 1'b0);
            check(32'(settings[bit_c[i]]), 32'h0);
        end
        device_fault <= 1'b1;
        cmd(8'h07, 8'h00, 1'b0);
        device_fault <= 1'b0;
        check(32'(spins), 32'h1);
        cmd(8'h04, 8'h00, 1'b1);
        cmd(8'hf0, 8'h00, 1'b1);
        cmd(8'h01, 8'h00, 1'b1);
        cmd(8'h81, 8'h00, 1'b1);
        check(32'({settings.pio8, data_8bit}), 32'h0);
    endtask : t_toggles
    task t_xfer;
        cmd(8'h03, 8'h01, 1'b0);
        check(32'({settings.iordy_off, iordy_en}), 32'h2);
        for (int m = 0; m <= 4; m++)
        begin
            cmd(8'h03, {5'h01, m[2:0]}, 1'b0);
            check(32'({modes.pio_valid, modes.pio_mode}), 32'({1'b1, m[2:0]}));
        end
        check(32'({settings.iordy_off, iordy_en}), 32'h1);
        cmd(8'h03, 8'h0d, 1'b1);
        for (int m = 0; m <= 2; m++)
        begin
            cmd(8'h03, {5'h04, m[2:0]}, 1'b0);
            check(32'({modes.mw_valid, modes.mw_mode, modes.udma_valid}), 32'({1'b1, m[2:0], 1'b0}));
        end
        // Cable taken as 80-wire, so modes above 2 are legal
        for (int m = 0; m <= 5; m++)
        begin
            cmd(8'h03, {5'h08, m[2:0]}, 1'b0);
            check(32'({modes.udma_valid, modes.udma_mode, modes.mw_valid}), 32'({1'b1, m[2:0], 1'b0}));
        end
        cmd(8'h03, 8'h46, 1'b1);
        check(32'(modes.udma_mode), 32'h5);
        cmd(8'h03, 8'h10, 1'b1);
        cmd(8'h03, 8'h80, 1'b1);
        cmd(8'h03, 8'h00, 1'b0);
        check(32'(settings.iordy_off), 32'h0);
    endtask : t_xfer
    task t_power;
        for (int i = 0; i < 4; i++)
        begin
            cmd(8'h05, lv[i], 1'b0);
            check(32'({settings.apm_en, apm_level}), 32'({1'b1, lv[i]}));
            if (lv[i] >= 8'h80) check(32'(spindown_allowed), 32'h0);
        end
        cmd(8'h05, 8'h00, 1'b1);
        cmd(8'h05, 8'hff, 1'b1);
        check(32'(apm_level), 32'hfe);
        cmd(8'h85, 8'h00, 1'b0);
        check(32'(settings.apm_en), 32'h0);
        cmd(8'h42, 8'h80, 1'b0);
        check(32'({settings.acous_en, acous_level}), 32'h180);
        cmd(8'h42, 8'hff, 1'b1);
        cmd(8'hc2, 8'h00, 1'b0);
        check(32'(settings.acous_en), 32'h0);
    endtask : t_power
    task t_wcache;
        int n;
        n = 0;
        delay <= 4'h9;
        issue(8'h82, 8'h00);
        while (flush_req !== 1'b1 && n < 30)
        begin
            @(posedge pclk);
            n++;
        end
        issue(8'haa, 8'h00);
        rd(8'h04);
        check(32'({q[7], flush_req}), 32'h3);
        finish(1'b0);
        check(32'({settings.wcache, settings.lookahead}), 32'h0);
        delay <= 4'h0;
        cmd(8'h02, 8'h00, 1'b0);
        check(32'(settings.wcache), 32'h1);
        cmd(8'h82, 8'h00, 1'b0);
        check(32'(settings.wcache), 32'h0);
    endtask : t_wcache
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, device_fault} = '0;
        clk_en = 1'b1;
        delay = 4'h2;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_toggles();
        t_xfer();
        t_power();
        t_wcache();
        wrap_up();
    end
    initial
    begin
        #800000;
        n_mismatch++;
        wrap_up();
    end
endmodule : test_set_features_decoder
`default_nettype wire
